// ==== verilog/srs_pkg.sv ====
package srs_pkg;

  // word timing on the serial bus
  localparam int unsigned WORD_BITS = 56;
  localparam logic [5:0] BIT_FIRST = 6'h00;
  localparam logic [5:0] BIT_LAST = 6'h37;
  localparam int unsigned INS_BITS = 10;
  localparam logic [3:0] INS_LAST = 4'h9;

  // bit times of the loaded address: register field then chip field
  localparam logic [5:0] ADDR_LAST_BIT = 6'h09;
  localparam int unsigned REG_ADDR_LSB = 0;
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned CHIP_ADDR_LSB = 4;
  localparam int unsigned CHIP_ADDR_W = 6;

  // instruction layout: register number sits in the four top bits
  localparam int unsigned INS_REG_LSB = 6;
  localparam int unsigned INS_LOW_W = 6;

  // instruction codes, implementation defined
  localparam logic [9:0] OPC_ADDR_LOAD = 10'h3F0;
  localparam logic [9:0] OPC_IND_WRITE = 10'h2F0;
  localparam logic [9:0] OPC_IND_READ = 10'h0F0;
  localparam logic [5:0] OPC_DIR_WRITE_LOW = 6'h28;
  localparam logic [5:0] OPC_DIR_READ_LOW = 6'h38;

  // values after reset
  localparam logic [3:0] REG_ADDR_RST = 4'h0;
  localparam logic [5:0] CHIP_ADDR_RST = 6'h00;
  localparam logic FIXED_ADDRESS_MSB = 1'b0;

  // bus operation carried out during one word time
  typedef enum logic [1:0] {
    SRS_OP_IDLE = 2'b00,
    SRS_OP_LOAD = 2'b01,
    SRS_OP_WRITE = 2'b10,
    SRS_OP_READ = 2'b11
  } srs_op_t;

endpackage : srs_pkg

// ==== verilog/srs_word_store.sv ====
`timescale 1ns/1ps
module srs_word_store
  import srs_pkg::*;
#(
  parameter int unsigned DATA_W = 56,
  parameter int unsigned REG_COUNT = 16,
  parameter int unsigned IDX_W = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_word,
  // read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_word
);

  initial begin
    if (REG_COUNT > (1 << IDX_W) || DATA_W == 0) begin
      $error("srs_word_store: bad geometry");
    end
  end

  logic [DATA_W-1:0] mem_q [REG_COUNT];

  // one word per entry; contents only change on a full write or on reset
  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_word
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[i] <= '0;
        end else if (wr_en && wr_idx == IDX_W'(i)) begin
          mem_q[i] <= wr_word;
        end
      end
    end
  endgenerate

  assign rd_word = mem_q[rd_idx];

endmodule : srs_word_store

// ==== verilog/srs_storage_chip.sv ====
`timescale 1ns/1ps
// Function
// - Hold sixteen registers of 56 bits, kept between accesses.
// - Answer to a six-bit chip address, thirty-two chips per bus.
// - Top chip address bit is zero; lower five bits come from straps.
// - Inputs sampled on phase one; outputs start on phase two edges.
// - Instruction read serially during sync; five codes decoded, others ignored.
// - Instruction line ignored while sync is low; sync aligns word timing.
// - Data line undriven except while a read instruction executes.
// - After power-on rises, become active at next falling edge of sync.
// - Power-on low halts the chip and blocks inputs, contents kept.
// - Test input low forces the data line undriven.
// - Address load takes ten address bits at times 0 to 9.
// - Times 0-3 give register, times 4-9 give chip, LSB first.
// - Chip address kept until next address load or power-on; register address also replaced by direct write.
// - Chip with mismatching address ignores following register instructions.
// - Indirect write stores next word into the addressed register.
// - Indirect read drives the addressed register during next word.
// - Direct write takes register from top four instruction bits, replaces address.
// - Direct read of 1-15 outputs that register; zero acts as indirect read.
// - A data word occupies bit times 0 through 55.
// - Everything on the bus travels least significant bit first.
module srs_storage_chip
  import srs_pkg::*;
#(
  parameter int unsigned DATA_W = 56,
  parameter int unsigned REG_COUNT = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus clock phases and word sync from the host
  input wire logic phase1,
  input wire logic phase2,
  input wire logic sync,
  input wire logic instruction_line,
  input wire logic power_on_indication,
  // board straps and test
  input wire logic [4:0] chip_select_straps,
  input wire logic test_n,
  // shared serial data line
  input wire logic data_in,
  output logic data_out,
  output logic data_oe
);

  localparam int unsigned IDX_W = REG_ADDR_W;

  initial begin
    if (DATA_W != WORD_BITS || REG_COUNT != (1 << IDX_W)) begin
      $error("srs_storage_chip: geometry must match the bus word and register field");
    end
  end

  // indirect codes must not alias a direct pattern, or some register numbers would be lost
  initial begin
    if (OPC_IND_WRITE[INS_LOW_W-1:0] == OPC_DIR_WRITE_LOW
        || OPC_IND_WRITE[INS_LOW_W-1:0] == OPC_DIR_READ_LOW
        || OPC_IND_READ[INS_LOW_W-1:0] == OPC_DIR_WRITE_LOW
        || OPC_IND_READ[INS_LOW_W-1:0] == OPC_DIR_READ_LOW
        || OPC_ADDR_LOAD[INS_LOW_W-1:0] == OPC_DIR_WRITE_LOW
        || OPC_ADDR_LOAD[INS_LOW_W-1:0] == OPC_DIR_READ_LOW) begin
      $error("srs_storage_chip: opcode table aliases a direct instruction");
    end
  end

  // all chip state in one record; the two phase samples feed the edge detectors
  typedef struct packed {
    logic ph1;
    logic ph2;
    logic sync;
    logic active;
    logic [INS_BITS-1:0] ins_sr;
    logic [3:0] ins_cnt;
    logic [5:0] bit_cnt;
    srs_op_t op;
    srs_op_t pend;
    logic [IDX_W-1:0] pend_idx;
    logic [IDX_W-1:0] op_idx;
    logic [IDX_W-1:0] reg_addr;
    logic [CHIP_ADDR_W-1:0] chip_addr;
    logic [CHIP_ADDR_W+REG_ADDR_W-1:0] addr_sr;
    logic [DATA_W-1:0] word_sr;
    logic dout;
  } srs_state_t;

  // after reset the chip is inactive and waits for power-on and a sync edge
  localparam srs_state_t STATE_RST = '{
    ph1: 1'b0,
    ph2: 1'b0,
    sync: 1'b0,
    active: 1'b0,
    ins_sr: '0,
    ins_cnt: 4'h0,
    bit_cnt: BIT_FIRST,
    op: SRS_OP_IDLE,
    pend: SRS_OP_IDLE,
    pend_idx: REG_ADDR_RST,
    op_idx: REG_ADDR_RST,
    reg_addr: REG_ADDR_RST,
    chip_addr: CHIP_ADDR_RST,
    addr_sr: '0,
    word_sr: '0,
    dout: 1'b0
  };

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_int_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // only the second flop is read, so release never meets a half-settled value
  assign rst_int_n = rst_sync_q[1];

  srs_state_t s_q;
  srs_state_t s_d;

  // storage port signals
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] rd_word;

  // phase edges and the comparison of strapped and loaded chip address
  logic ph1_rise;
  logic ph2_rise;
  logic selected;
  logic [INS_BITS-1:0] ins_full;
  logic [CHIP_ADDR_W+REG_ADDR_W-1:0] addr_full;
  logic [DATA_W-1:0] word_full;
  logic [IDX_W-1:0] ins_reg;
  // opcode matches on the assembled instruction
  logic dec_load;
  logic dec_ind_write;
  logic dec_ind_read;
  logic dec_dir_write;
  logic dec_dir_read;

  // a low power-on indication stops both internal clocks
  assign ph1_rise = phase1 && !s_q.ph1 && power_on_indication;
  assign ph2_rise = phase2 && !s_q.ph2 && power_on_indication;
  assign selected = (s_q.chip_addr == {FIXED_ADDRESS_MSB, chip_select_straps});

  // serial fields shift in from the top so the first bit ends at bit 0
  assign ins_full = {instruction_line, s_q.ins_sr[INS_BITS-1:1]};
  assign addr_full = {data_in, s_q.addr_sr[CHIP_ADDR_W+REG_ADDR_W-1:1]};
  assign word_full = {data_in, s_q.word_sr[DATA_W-1:1]};
  assign ins_reg = ins_full[INS_BITS-1:INS_REG_LSB];

  // five codes only; any other pattern leaves the pending operation idle
  // direct codes match the low six bits alone, since the top four carry the register
  assign dec_load = (ins_full == OPC_ADDR_LOAD);
  assign dec_ind_write = (ins_full == OPC_IND_WRITE);
  assign dec_ind_read = (ins_full == OPC_IND_READ);
  assign dec_dir_write = (ins_full[INS_LOW_W-1:0] == OPC_DIR_WRITE_LOW);
  assign dec_dir_read = (ins_full[INS_LOW_W-1:0] == OPC_DIR_READ_LOW);

  // write to storage when the last data bit of a write word is sampled
  assign wr_en = ph1_rise && s_q.active && s_q.op == SRS_OP_WRITE
                 && s_q.bit_cnt == BIT_LAST;
  assign wr_idx = s_q.op_idx;
  assign wr_word = word_full;

  // next-state logic for the whole chip
  always_comb begin
    s_d = s_q;
    s_d.ph1 = phase1;
    s_d.ph2 = phase2;

    if (!power_on_indication) begin
      // power down: stop activity but keep addresses and contents
      s_d.active = 1'b0;
      s_d.op = SRS_OP_IDLE;
      s_d.pend = SRS_OP_IDLE;
      s_d.ins_cnt = 4'h0;
      s_d.dout = 1'b0;
    end

    // phase two starts each bit time: advance the counter, launch data
    if (ph2_rise) begin
      if (s_q.bit_cnt == BIT_LAST) begin
        s_d.bit_cnt = BIT_FIRST;
        s_d.op = s_q.pend;
        s_d.op_idx = s_q.pend_idx;
        s_d.pend = SRS_OP_IDLE;
        // the whole register is copied at once, so the word cannot tear mid-read
        if (s_q.pend == SRS_OP_READ) begin
          s_d.word_sr = rd_word;
          s_d.dout = rd_word[0];
        end
      end else begin
        s_d.bit_cnt = s_q.bit_cnt + 6'h01;
        if (s_q.op == SRS_OP_READ) begin
          s_d.word_sr = {1'b0, s_q.word_sr[DATA_W-1:1]};
          s_d.dout = s_q.word_sr[1];
        end
      end
      if (s_q.bit_cnt == BIT_LAST && s_q.pend != SRS_OP_READ) begin
        s_d.dout = 1'b0;
      end
    end

    // phase one samples sync, instruction and data
    if (ph1_rise) begin
      s_d.sync = sync;

      // activation waits for a falling edge of sync after power-on
      if (!s_q.active && s_q.sync && !sync) begin
        s_d.active = 1'b1;
        s_d.reg_addr = REG_ADDR_RST;
        s_d.chip_addr = CHIP_ADDR_RST;
      end

      // instruction bits only count while sync is high
      if (!sync) begin
        s_d.ins_cnt = 4'h0;
      end else if (s_q.active) begin
        s_d.ins_sr = ins_full;
        s_d.ins_cnt = s_q.ins_cnt + 4'h1;
        if (s_q.ins_cnt == INS_LAST) begin
          // last instruction bit: the next phase two begins bit time 0
          s_d.ins_cnt = 4'h0;
          s_d.bit_cnt = BIT_LAST;
          s_d.pend = SRS_OP_IDLE;
          if (dec_load) begin
            s_d.pend = SRS_OP_LOAD;
          end else if (selected) begin
            if (dec_ind_write) begin
              s_d.pend = SRS_OP_WRITE;
              s_d.pend_idx = s_q.reg_addr;
            end else if (dec_ind_read) begin
              s_d.pend = SRS_OP_READ;
              s_d.pend_idx = s_q.reg_addr;
            end else if (dec_dir_write) begin
              s_d.pend = SRS_OP_WRITE;
              s_d.pend_idx = ins_reg;
              s_d.reg_addr = ins_reg;
            end else if (dec_dir_read) begin
              s_d.pend = SRS_OP_READ;
              s_d.pend_idx = (ins_reg == '0) ? s_q.reg_addr : ins_reg;
            end
          end
        end
      end

      // address load: ten bits in bit times 0 to 9
      if (s_q.active && s_q.op == SRS_OP_LOAD && s_q.bit_cnt <= ADDR_LAST_BIT) begin
        s_d.addr_sr = addr_full;
        if (s_q.bit_cnt == ADDR_LAST_BIT) begin
          s_d.reg_addr = addr_full[REG_ADDR_LSB +: REG_ADDR_W];
          s_d.chip_addr = addr_full[CHIP_ADDR_LSB +: CHIP_ADDR_W];
        end
      end

      // write word gathered over bit times 0 to 55
      if (s_q.active && s_q.op == SRS_OP_WRITE) begin
        s_d.word_sr = word_full;
      end
    end
  end

  // single register stage for all chip state
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // register storage
  srs_word_store #(
    .DATA_W(DATA_W),
    .REG_COUNT(REG_COUNT),
    .IDX_W(IDX_W)
  ) u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_int_n),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_word(wr_word),
    .rd_idx(s_q.pend_idx),
    .rd_word(rd_word)
  );

  // drive only during a read word; the test pin gates the enable through a
  // single and-term so a faulty chip can always be taken off the shared line
  logic drive_word;
  assign data_out = s_q.dout;
  assign drive_word = s_q.active && (s_q.op == SRS_OP_READ);
  assign data_oe = test_n && power_on_indication && drive_word;

endmodule : srs_storage_chip

// ==== testbench/srs_host_model.sv ====
`timescale 1ns/1ps
module srs_host_model (
  // clock and phase enable
  input wire logic clk_sys,
  input wire logic run,
  // bus phases
  output logic phase1,
  output logic phase2,
  output logic [2:0] slot_q,
  // shared data line
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic drv_en,
  input wire logic drv_bit,
  output logic data_in
);
  logic last_q = 1'b0;
  initial slot_q = 3'h0;
  // eight clocks a bit time; phases stand still while run is low
  always @(posedge clk_sys) begin
    slot_q <= run ? slot_q + 3'h1 : 3'h0;
    last_q <= data_in;
  end
  assign phase2 = run && (slot_q == 3'h1 || slot_q == 3'h2);
  assign phase1 = run && (slot_q == 3'h5 || slot_q == 3'h6);
  // a released line shows the inverse level so a stale copy is never read
  assign data_in = data_oe ? data_out : (drv_en ? drv_bit : ~last_q);
endmodule : srs_host_model

// ==== testbench/srs_storage_chip_sva.sv ====
`timescale 1ns/1ps
module srs_storage_chip_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus inputs
  input wire logic phase2,
  input wire logic sync,
  input wire logic power_on_indication,
  input wire logic test_n,
  // data line drive
  input wire logic data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [5:0] bits_q;
  logic [7:0] gap_q;
  // phase-two rises while driving, and clocks since sync was last high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bits_q <= 6'h00;
      gap_q <= 8'hFF;
    end else begin
      bits_q <= !data_oe ? 6'h00 : bits_q + {5'h00, $rose(phase2)};
      gap_q <= sync ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
    end
  end
  property p_test_off; !test_n |-> !data_oe; endproperty
  a_test_off: assert property (p_test_off) else $error("drive with test low");
  property p_power_off; !power_on_indication |-> !data_oe; endproperty
  a_power_off: assert property (p_power_off) else $error("drive with power low");
  property p_oe_on_p2;
    $changed(data_oe) && test_n && $past(test_n) && power_on_indication |-> $past(phase2);
  endproperty
  a_oe_on_p2: assert property (p_oe_on_p2) else $error("enable moved off phase two");
  property p_dout_on_p2; $changed(data_out) && data_oe |-> $past(phase2); endproperty
  a_dout_on_p2: assert property (p_dout_on_p2) else $error("data moved off phase two");
  property p_word_len; $fell(data_oe) && test_n && power_on_indication |-> bits_q == 6'h38;
  endproperty
  a_word_len: assert property (p_word_len) else $error("read word not 56 bits");
  property p_read_cause; $rose(data_oe) && $past(test_n) |-> gap_q <= 8'h10; endproperty
  a_read_cause: assert property (p_read_cause) else $error("drive without instruction");
  property p_wake_quiet; $rose(power_on_indication) |-> !data_oe [*8]; endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("drive at power up");
  property p_hold_bit; $rose(data_oe) |-> data_oe [*8]; endproperty
  a_hold_bit: assert property (p_hold_bit) else $error("drive dropped in bit");
endmodule : srs_storage_chip_sva
bind srs_storage_chip srs_storage_chip_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .phase2(phase2), .sync(sync), .power_on_indication(power_on_indication),
  .test_n(test_n), .data_out(data_out), .data_oe(data_oe));

// ==== testbench/test_serial_register_storage.sv ====
`timescale 1ns/1ps
module test_serial_register_storage;
  import srs_pkg::*;
  logic clk_sys, rst_n, run, sync, instruction_line, power_on_indication, test_n;
  logic drv_en, drv_bit, phase1, phase2, data_in, data_out, data_oe;
  logic [4:0] chip_select_straps;
  logic [2:0] slot_q;
  logic [55:0] g_w, g_v;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [55:0] W1 = 56'hA5C30F961E78B4;
  localparam logic [55:0] W2 = 56'h8123456789ABCD;
  localparam logic [9:0] OPC_BAD = 10'h155;
  srs_host_model u_host (.clk_sys(clk_sys), .run(run), .phase1(phase1), .phase2(phase2),
    .slot_q(slot_q), .data_out(data_out), .data_oe(data_oe), .drv_en(drv_en),
    .drv_bit(drv_bit), .data_in(data_in));
  srs_storage_chip DUT (.clk_sys(clk_sys), .rst_n(rst_n), .phase1(phase1), .phase2(phase2),
    .sync(sync), .instruction_line(instruction_line),
    .power_on_indication(power_on_indication), .chip_select_straps(chip_select_straps),
    .test_n(test_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [55:0] exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // drive at the start of a bit time, sample once phase one is up
  task automatic bit_time(input logic s, i, de, d, output logic o, e);
    @(posedge clk_sys iff slot_q == 3'h7);
    sync <= s;
    instruction_line <= i;
    drv_en <= de;
    drv_bit <= d;
    @(posedge clk_sys iff slot_q == 3'h5);
    o = data_out;
    e = data_oe;
  endtask : bit_time
  // ten sync bits of instruction, then one word; the word also toggles the idle line
  task automatic xfer(input logic [9:0] ins, input logic de, input logic [55:0] w);
    logic o, e;
    for (int k = 0; k < 10; k++) begin
      bit_time(1'b1, ins[k], 1'b0, 1'b0, o, e);
    end
    for (int k = 0; k < 56; k++) begin
      bit_time(1'b0, w[k], de, w[k], o, e);
      g_w[k] = o;
      g_v[k] = e;
    end
  endtask : xfer
  task automatic rd(input logic [9:0] ins, input logic ex, input logic [55:0] w);
    xfer(ins, 1'b0, 56'h0);
    chk("drive", {56{ex}}, g_v);
    if (ex) begin
      chk("word", w, g_w);
    end
  endtask : rd
  task automatic load(input logic [3:0] r, input logic [5:0] c);
    xfer(OPC_ADDR_LOAD, 1'b1, {46'h0, c, r});
  endtask : load
  task automatic t_wake;
    rd(OPC_IND_READ, 1'b0, 56'h0);
    power_on_indication <= 1'b1;
    rd(OPC_BAD, 1'b0, 56'h0);
    rd(OPC_IND_READ, 1'b1, 56'h0);
  endtask : t_wake
  task automatic t_direct;
    load(4'h5, 6'h00);
    xfer({4'h3, OPC_DIR_WRITE_LOW}, 1'b1, W1);
    rd(OPC_IND_READ, 1'b1, W1);
    rd({4'h0, OPC_DIR_READ_LOW}, 1'b1, W1);
    load(4'h5, 6'h00);
    xfer(OPC_IND_WRITE, 1'b1, W2);
    rd({4'h5, OPC_DIR_READ_LOW}, 1'b1, W2);
    rd({4'h3, OPC_DIR_READ_LOW}, 1'b1, W1);
  endtask : t_direct
  task automatic t_test;
    test_n <= 1'b0;
    rd(OPC_IND_READ, 1'b0, W2);
    rd(OPC_BAD, 1'b0, W2);
    test_n <= 1'b1;
  endtask : t_test
  task automatic t_select;
    chip_select_straps <= 5'h11;
    rd(OPC_IND_READ, 1'b0, W2);
    load(4'h5, 6'h31);
    rd(OPC_IND_READ, 1'b0, W2);
    load(4'h5, 6'h11);
    rd(OPC_IND_READ, 1'b1, W2);
    chip_select_straps <= 5'h00;
  endtask : t_select
  task automatic t_power;
    power_on_indication <= 1'b0;
    rd(OPC_IND_READ, 1'b0, W2);
    power_on_indication <= 1'b1;
    rd(OPC_BAD, 1'b0, W2);
    rd(OPC_IND_READ, 1'b1, 56'h0);
    load(4'h3, 6'h00);
    rd(OPC_IND_READ, 1'b1, W1);
  endtask : t_power
  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // a hang is cut short well past the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // reset, then start the bus phases and run the scenarios
  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    sync = 1'b0;
    instruction_line = 1'b0;
    power_on_indication = 1'b0;
    test_n = 1'b1;
    drv_en = 1'b0;
    drv_bit = 1'b0;
    chip_select_straps = 5'h00;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    run <= 1'b1;
    t_wake();
    t_direct();
    t_test();
    t_select();
    t_power();
    tally_and_finish();
  end
endmodule : test_serial_register_storage
